/* File: common/ldc_pkg.sv */
// Function
// - each channel's sink current scales with its 6-bit trim; code 63 is full.
// - bank_select high makes the shifter a 96-bit trim register with 96-bit latch.
// - trim bits on serial_in are captured on each rising shift clock, MSB first.
// - latch_strobe rising with bank_select high copies the shifter into the trim latch.
// - trim latching needs no inhibit; new trim acts at once on lit outputs.
// - a 12-bit counter advances on each rising pwm_ref_clock edge.
// - output_inhibit clears and holds the counter at zero; counting resumes after it falls.
// - nonzero-level channels turn on at the first pwm_ref_clock rise after inhibit falls.
// - channel stays on while counter <= level, turns off once counter exceeds it.
// - at fff the counter stops; from the next edge outputs stay off until inhibit is pulsed.
// - raising inhibit before the terminal count resets the counter at once.
// - all sixteen outputs are off while output_inhibit is high.
// - on-time equals level times one pwm_ref_clock period, level 0 to 4095.
// - latching levels mid-cycle updates the level latch at once.
// - bank_select low makes the shifter a 192-bit level register with 192-bit latch.
// - level bits on serial_in are captured on each rising shift clock, MSB first.
// - latch_strobe rising with bank_select low copies the shifter into the level latch.
// - the shifter's outgoing bit appears on serial_out for daisy chaining.
package ldc_pkg;

  // ==========================================================
  // geometry
  localparam int CHANNELS = 16;
  localparam int TRIM_W = 6;
  localparam int LEVEL_W = 12;
  localparam int TRIM_BITS = 96;
  localparam int LEVEL_BITS = 192;
  localparam logic [11:0] CNT_TERMINAL = 12'hfff;

  // ==========================================================
  // synchroniser lanes for the pin inputs
  localparam int PIN_COUNT = 6;
  localparam int PIN_SHIFT_CLK = 0;
  localparam int PIN_SERIAL_IN = 1;
  localparam int PIN_LATCH = 2;
  localparam int PIN_BANK = 3;
  localparam int PIN_PWM_CLK = 4;
  localparam int PIN_INHIBIT = 5;
  localparam logic [5:0] PIN_RESET = 6'h00;

  // ==========================================================
  // register map (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_CHAN_SEL = 12'h008;
  localparam logic [11:0] OFS_CHAN_DATA = 12'h00c;

  // field positions
  localparam int CTRL_SOFT_INHIBIT_BIT = 0;
  localparam int STATUS_DONE_BIT = 12;
  localparam int STATUS_INHIBIT_BIT = 13;
  localparam int STATUS_BANK_BIT = 14;
  localparam int STATUS_RUN_BIT = 15;
  localparam int CHAN_DATA_TRIM_LSB = 12;

  // reset values
  localparam logic CTRL_SOFT_INHIBIT_RESET = 1'b1;
  localparam logic [3:0] CHAN_SEL_RESET = 4'h0;

  // ==========================================================
  // pwm cycle phases
  typedef enum logic [2:0] {
    PH_HELD = 3'b001,
    PH_RUN = 3'b010,
    PH_DONE = 3'b100
  } ldc_phase_type;

endpackage

/* File: hdl/ldc_core.sv */
`timescale 1ns/1ps
`default_nettype none
module ldc_core import ldc_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic shift_clock,
  input wire logic serial_in,
  input wire logic latch_strobe,
  input wire logic bank_select,
  input wire logic pwm_ref_clock,
  input wire logic output_inhibit,
  output logic serial_out,
  output logic [CHANNELS-1:0] sink_output,
  output logic [TRIM_BITS-1:0] sink_current_code
);

  // ==========================================================
  // pin synchronisation and edge detection
  logic [PIN_COUNT-1:0] pin_sync;
  logic [PIN_COUNT-1:0] pin_prev_reg;
  logic sck_rise;
  logic strobe_rise;
  logic pwm_rise;
  logic bank_s;
  logic sin_s;
  logic inhibit_eff;

  ldc_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({output_inhibit, pwm_ref_clock, bank_select, latch_strobe, serial_in, shift_clock}),
    .sync_out(pin_sync)
  );

  // previous synced value, for edge finding only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_prev_reg <= PIN_RESET;
    end else begin
      pin_prev_reg <= pin_sync;
    end
  end

  // serial_in passes the same two stages as the shift clock, so skew is preserved
  assign sck_rise = pin_sync[PIN_SHIFT_CLK] & ~pin_prev_reg[PIN_SHIFT_CLK];
  assign strobe_rise = pin_sync[PIN_LATCH] & ~pin_prev_reg[PIN_LATCH];
  assign pwm_rise = pin_sync[PIN_PWM_CLK] & ~pin_prev_reg[PIN_PWM_CLK];
  assign bank_s = pin_sync[PIN_BANK];
  assign sin_s = pin_sync[PIN_SERIAL_IN];

  // ==========================================================
  // serial shifter and latches
  logic [LEVEL_BITS-1:0] shift_reg;
  logic [LEVEL_BITS-1:0] level_reg;
  logic [TRIM_BITS-1:0] trim_reg;
  logic soft_inhibit_reg;
  logic [3:0] chan_sel_reg;

  // one shifter serves both banks; the trim bank only uses its low 96 bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_reg <= '0;
    end else if (sck_rise) begin
      shift_reg <= {shift_reg[LEVEL_BITS-2:0], sin_s};
    end
  end

  // the outgoing bit is the top of whichever bank is selected
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_out <= 1'b0;
    end else begin
      serial_out <= bank_s ? shift_reg[TRIM_BITS-1] : shift_reg[LEVEL_BITS-1];
    end
  end

  // trim latch: no inhibit needed, takes effect on the next drive update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trim_reg <= '0;
    end else if (strobe_rise && bank_s) begin
      trim_reg <= shift_reg[TRIM_BITS-1:0];
    end
  end

  // level latch is loaded whole in one pclk edge, so compares never see a torn value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level_reg <= '0;
    end else if (strobe_rise && !bank_s) begin
      level_reg <= shift_reg;
    end
  end

  // ==========================================================
  // pwm counter and phase
  ldc_phase_type phase_reg;
  logic [LEVEL_W-1:0] cnt_reg;

  // software inhibit adds to the pin, it never overrides a pin inhibit
  assign inhibit_eff = pin_sync[PIN_INHIBIT] | soft_inhibit_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= PH_HELD;
      cnt_reg <= '0;
    end else if (inhibit_eff) begin
      phase_reg <= PH_HELD;
      cnt_reg <= '0;
    end else if (pwm_rise) begin
      case (phase_reg)
        PH_HELD: begin
          phase_reg <= PH_RUN;
          cnt_reg <= 12'h001;
        end
        PH_RUN: begin
          if (cnt_reg == CNT_TERMINAL) begin
            phase_reg <= PH_DONE;
          end else begin
            cnt_reg <= cnt_reg + 12'h001;
          end
        end
        PH_DONE: begin
          cnt_reg <= cnt_reg;
        end
        default: begin
          phase_reg <= PH_HELD;
          cnt_reg <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // per-channel compare and current drive
  logic [CHANNELS-1:0] chan_on;
  logic [CHANNELS-1:0] lvl_nz;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch++) begin : g_chan
      // counter starts at 1 in run, so on-time is level periods exactly
      assign chan_on[ch] = !inhibit_eff && (phase_reg == PH_RUN) &&
        (cnt_reg <= level_reg[ch*LEVEL_W +: LEVEL_W]);

      // nonzero-level mask, only read by the first-edge check
      assign lvl_nz[ch] = |level_reg[ch*LEVEL_W +: LEVEL_W];

      // current code is zero when off, the trim code (63 = full) when on
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sink_output[ch] <= 1'b0;
          sink_current_code[ch*TRIM_W +: TRIM_W] <= '0;
        end else begin
          sink_output[ch] <= chan_on[ch];
          sink_current_code[ch*TRIM_W +: TRIM_W] <= chan_on[ch] ? trim_reg[ch*TRIM_W +: TRIM_W] : '0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // apb slave: zero wait states, read data staged in the setup cycle
  logic apb_setup;
  logic apb_write;
  logic [31:0] rdata_next;
  logic err_next;

  assign apb_setup = psel & ~penable;
  assign apb_write = psel & penable & pready & pwrite;

  // read mux; unmapped addresses answer zero with pslverr
  always_comb begin
    rdata_next = 32'h0000_0000;
    err_next = 1'b0;
    if (paddr == OFS_CTRL) begin
      rdata_next[CTRL_SOFT_INHIBIT_BIT] = soft_inhibit_reg;
    end else if (paddr == OFS_STATUS) begin
      rdata_next[LEVEL_W-1:0] = cnt_reg;
      rdata_next[STATUS_DONE_BIT] = (phase_reg == PH_DONE);
      rdata_next[STATUS_INHIBIT_BIT] = inhibit_eff;
      rdata_next[STATUS_BANK_BIT] = bank_s;
      rdata_next[STATUS_RUN_BIT] = (phase_reg == PH_RUN);
    end else if (paddr == OFS_CHAN_SEL) begin
      rdata_next[3:0] = chan_sel_reg;
    end else if (paddr == OFS_CHAN_DATA) begin
      rdata_next[LEVEL_W-1:0] = level_reg[int'(chan_sel_reg)*LEVEL_W +: LEVEL_W];
      rdata_next[CHAN_DATA_TRIM_LSB +: TRIM_W] = trim_reg[int'(chan_sel_reg)*TRIM_W +: TRIM_W];
    end else begin
      err_next = 1'b1;
    end
  end

  // answer flops; pready rises only in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_next;
        pslverr <= err_next;
      end
    end
  end

  // writable registers; read-only offsets ignore writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_inhibit_reg <= CTRL_SOFT_INHIBIT_RESET;
      chan_sel_reg <= CHAN_SEL_RESET;
    end else if (apb_write) begin
      if (paddr == OFS_CTRL) begin
        soft_inhibit_reg <= pwdata[CTRL_SOFT_INHIBIT_BIT];
      end else if (paddr == OFS_CHAN_SEL) begin
        chan_sel_reg <= pwdata[3:0];
      end
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_inhibit_clear;
    inhibit_eff |=> (cnt_reg == 12'h000) && (phase_reg == PH_HELD);
  endproperty
  a_inhibit_clear: assert property (p_inhibit_clear) else $error("counter not cleared by inhibit");

  property p_inhibit_off;
    inhibit_eff |=> (sink_output == 16'h0000) && (sink_current_code == '0);
  endproperty
  a_inhibit_off: assert property (p_inhibit_off) else $error("output on during inhibit");

  property p_count_step;
    (!inhibit_eff && pwm_rise && phase_reg == PH_RUN && cnt_reg != CNT_TERMINAL)
      |=> cnt_reg == $past(cnt_reg) + 12'h001;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not advance");

  property p_count_hold;
    (!inhibit_eff && !pwm_rise) |=> $stable(cnt_reg);
  endproperty
  a_count_hold: assert property (p_count_hold) else $error("counter moved without edge");

  property p_terminal;
    (phase_reg == PH_DONE && !inhibit_eff) |=> (cnt_reg == CNT_TERMINAL) ##1 (sink_output == 16'h0000);
  endproperty
  a_terminal: assert property (p_terminal) else $error("counter left terminal or output lit");

  property p_first_edge;
    (!inhibit_eff && pwm_rise && phase_reg == PH_HELD)
      ##1 !inhibit_eff |=> sink_output == $past(lvl_nz);
  endproperty
  a_first_edge: assert property (p_first_edge) else $error("nonzero channels not on at first edge");

  property p_compare;
    (phase_reg == PH_RUN && !inhibit_eff)
      |=> sink_output[1] == ($past(cnt_reg) <= $past(level_reg[23:12]));
  endproperty
  a_compare: assert property (p_compare) else $error("channel 1 compare wrong");

  property p_shift;
    sck_rise |=> shift_reg[0] == $past(sin_s) && shift_reg[LEVEL_BITS-1:1] == $past(shift_reg[LEVEL_BITS-2:0]);
  endproperty
  a_shift: assert property (p_shift) else $error("shift capture wrong");

  property p_latch_level;
    (strobe_rise && !bank_s) |=> level_reg == $past(shift_reg);
  endproperty
  a_latch_level: assert property (p_latch_level) else $error("level latch not loaded");

  property p_latch_trim;
    (strobe_rise && bank_s) |=> trim_reg == $past(shift_reg[TRIM_BITS-1:0]) ##1
      (!sink_output[15] || sink_current_code[95:90] == $past(trim_reg[95:90]));
  endproperty
  a_latch_trim: assert property (p_latch_trim) else $error("trim latch not applied");

  property p_drive;
    !sink_output[0] |-> sink_current_code[5:0] == 6'h00;
  endproperty
  a_drive: assert property (p_drive) else $error("current drive while off");

  property p_chain;
    ##1 serial_out == $past(bank_s ? shift_reg[TRIM_BITS-1] : shift_reg[LEVEL_BITS-1]);
  endproperty
  a_chain: assert property (p_chain) else $error("serial_out mismatch");

  c_run_done: cover property (phase_reg == PH_RUN ##1 phase_reg == PH_DONE);
  c_abort: cover property (phase_reg == PH_RUN && inhibit_eff);
  c_trim_load: cover property (strobe_rise && bank_s);
  c_level_load_run: cover property (strobe_rise && !bank_s && phase_reg == PH_RUN);

endmodule // ldc_core
`default_nettype wire

/* File: hdl/ldc_sync.sv */
`timescale 1ns/1ps
`default_nettype none
// two-flop synchroniser; the first stage feeds only the second
module ldc_sync import ldc_pkg::*; #(
  parameter int WIDTH = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // ==========================================================
  // metastability filter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule // ldc_sync
`default_nettype wire

/* File: tb/ldc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// host model: moves the pins only just after pclk edges
module ldc_host_model import ldc_pkg::*; (
  input wire logic pclk,
  output logic shift_clock,
  output logic serial_in,
  output logic latch_strobe,
  output logic bank_select,
  output logic pwm_ref_clock,
  output logic output_inhibit
);
  // inhibit up from power-up so nothing lights before the latches are loaded
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    bank_select = 1'b0;
    pwm_ref_clock = 1'b0;
    output_inhibit = 1'b1;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // data set up 30 ns, clock high 30 ns and low 60 ns, so the synchroniser never misses a level
  task automatic send_bits(input logic [191:0] v, input int n, input logic bank);
    wait_n(1);
    bank_select <= bank;
    for (int i = n - 1; i >= 0; i--) begin
      wait_n(1);
      serial_in <= v[i];
      wait_n(3);
      shift_clock <= 1'b1;
      wait_n(3);
      shift_clock <= 1'b0;
      serial_in <= ~v[i]; // hold over: data no longer trustworthy
      wait_n(2);
    end
  endtask
  // bank was set before the shifts, so it is stable well ahead of the strobe
  task automatic latch();
    wait_n(5);
    latch_strobe <= 1'b1;
    wait_n(4);
    latch_strobe <= 1'b0;
    wait_n(5);
  endtask
  // one reference period of 130 ns, close to the 125 ns link rate
  task automatic pwm_pulse();
    wait_n(1);
    pwm_ref_clock <= 1'b1;
    wait_n(6);
    pwm_ref_clock <= 1'b0;
    wait_n(6);
  endtask
  task automatic set_inhibit(input logic v);
    wait_n(1);
    output_inhibit <= v;
    wait_n(6);
  endtask
endmodule // ldc_host_model
`default_nettype wire

/* File: tb/test_led_pwm_dot_correction_core.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// bench: apb plus host pins, expectations from fixed trim and level tables
module test_led_pwm_dot_correction_core import ldc_pkg::*;;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic shift_clock;
  logic serial_in;
  logic latch_strobe;
  logic bank_select;
  logic pwm_ref_clock;
  logic output_inhibit;
  logic serial_out;
  logic [15:0] sink_output;
  logic [95:0] sink_current_code;
  logic [31:0] rd;
  logic err;
  logic [191:0] tv;
  logic [191:0] lv;
  int n_errors;
  int cmp_count;
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  ldc_core dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shift_clock(shift_clock), .serial_in(serial_in), .latch_strobe(latch_strobe),
    .bank_select(bank_select), .pwm_ref_clock(pwm_ref_clock), .output_inhibit(output_inhibit),
    .serial_out(serial_out), .sink_output(sink_output), .sink_current_code(sink_current_code));
  ldc_host_model host (.pclk(pclk), .shift_clock(shift_clock), .serial_in(serial_in),
    .latch_strobe(latch_strobe), .bank_select(bank_select), .pwm_ref_clock(pwm_ref_clock),
    .output_inhibit(output_inhibit));
  // ch15 at full count so the terminal stop is reachable; ch0 plays an open load, so level zero
  function automatic logic [11:0] lvl(input int c);
    return (c == 15) ? 12'hfff : 12'(c);
  endfunction
  function automatic logic [5:0] trm(input int c);
    return 6'(63 - 4 * c);
  endfunction
  function automatic logic [15:0] lit(input int k);
    logic [15:0] m;
    for (int c = 0; c < 16; c++) m[c] = (lvl(c) >= 12'(k));
    return m;
  endfunction
  function automatic logic [95:0] code_of(input logic [15:0] m);
    logic [95:0] v;
    v = '0;
    for (int c = 0; c < 16; c++) if (m[c]) v[6*c +: 6] = trm(c);
    return v;
  endfunction
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one apb transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
      if (n > 20) begin
        n_errors++;
        wrap_up();
      end
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================
  // main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_errors = 0;
    cmp_count = 0;
    tv = '0;
    lv = '0;
    for (int c = 0; c < 16; c++) tv[6*c +: 6] = trm(c);
    for (int c = 0; c < 16; c++) lv[12*c +: 12] = lvl(c);
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 96'(CTRL_SOFT_INHIBIT_RESET));
    apb(1'b0, 12'h010, 32'h0);
    chk({rd, err}, 96'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    host.send_bits(tv, 96, 1'b1);
    host.latch();
    chk(serial_out, tv[95]);
    host.send_bits(lv, 192, 1'b0);
    host.latch();
    chk(serial_out, lv[191]);
    for (int c = 0; c < 16; c++) begin
      apb(1'b1, OFS_CHAN_SEL, 32'(c));
      apb(1'b0, OFS_CHAN_DATA, 32'h0);
      chk(rd, {trm(c), lvl(c)});
    end
    chk(sink_output, 96'h0);
    repeat (3) host.pwm_pulse();
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[11:0], 96'h0);
    host.set_inhibit(1'b0);
    for (int k = 1; k < 18; k++) begin
      host.pwm_pulse();
      chk(sink_output, lit(k));
      chk(sink_current_code, code_of(lit(k)));
      apb(1'b0, OFS_STATUS, 32'h0);
      chk(rd[11:0], 96'(k));
    end
    // mid-cycle level load: ch14 raised to full count turns back on at once
    host.send_bits(lv | (192'hfff << 168), 192, 1'b0);
    host.latch();
    chk(sink_output, lit(17) | 16'h4000);
    host.send_bits(~tv, 96, 1'b1);
    host.latch();
    chk(sink_current_code[95:90], 6'(~trm(15)));
    host.set_inhibit(1'b1);
    chk(sink_output, 96'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[11:0], 96'h0);
    host.set_inhibit(1'b0);
    repeat (4095) host.pwm_pulse();
    chk(sink_output, 96'hc000);
    host.pwm_pulse();
    chk(sink_output, 96'h0);
    host.pwm_pulse();
    chk(sink_output, 96'h0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[STATUS_DONE_BIT], 96'h1);
    wrap_up();
  end
endmodule // test_led_pwm_dot_correction_core
`default_nettype wire
